//--- logic/sto_sequencer.sv
`timescale 1ns/1ps

// Notes on behaviour
// - Run only with low input low and high input high; else safe torque off.
// - Keep oscillator powered about 400 ms after safe inputs drop.
// - Oscillator emits a constant-frequency pulse train while powered.
// - Driver supply gives no energy when the pulse train is absent.
// - Safe-state relay closes with auxiliary supply present and safety function active.
// - Relay closes 0.4 s to 1 s after inputs open, speed forced to zero.
// - Ready inputs alone do not enable; software enable must also be set.
// - Software stop: brake and zero setpoint at speed below 1% or after 1 s.
// - Software stop: engage brake, disable stage after 1 s plus brake delay.
// - Circuit opened: brake and zero setpoint at speed below 1% or after 500 ms.
// - Circuit opened: engage brake, disable stage after 500 ms plus brake delay.
module sto_sequencer #(
   parameter int unsigned MS_TICK_CYC = sto_pkg::CYC_PER_MS
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic safe_in_low,
   input wire logic safe_in_high,
   input wire logic aux_supply_ok,
   input wire logic sw_enable,
   input wire logic [sto_pkg::SPD_W-1:0] speed_actual,
   input wire logic [sto_pkg::SPD_W-1:0] speed_limit_a,
   input wire logic [sto_pkg::SPD_W-1:0] speed_limit_b,
   input wire logic [sto_pkg::SPD_W-1:0] brake_delay_time,
   output logic isolator_one,
   output logic isolator_two,
   output logic driver_supply_on,
   output logic power_stage_en,
   output logic controller_en,
   output logic brake_cmd,
   output logic brake_engage,
   output logic speed_setpoint_zero,
   output logic safe_state_relay,
   output logic [2:0] seq_state
);
   import sto_pkg::*;

   // True when speed is under one percent of the smaller limit
   function automatic logic below_pct(input logic [SPD_W-1:0] spd, input logic [SPD_W-1:0] la,
                                      input logic [SPD_W-1:0] lb);
      logic [SPD_W-1:0] lmin;
      logic [SPD_W+6:0] scaled;
      lmin = (la < lb) ? la : lb;
      scaled = (SPD_W+7)'(spd) * (SPD_W+7)'(PCT_SCALE);
      return scaled < (SPD_W+7)'(lmin);
   endfunction : below_pct

   // Pin synchronisers, two flops each
   logic low_s1_q;
   logic low_s2_q;
   logic high_s1_q;
   logic high_s2_q;
   logic aux_s1_q;
   logic aux_s2_q;

   // Millisecond tick
   logic [TICK_W-1:0] tick_q;
   logic [TICK_W-1:0] tick_d;
   logic ms_tick;

   // Hold-up and stop timers, in ms
   logic [MS_W-1:0] holdup_q;
   logic [MS_W-1:0] holdup_d;
   logic [MS_W-1:0] ramp_q;
   logic [MS_W-1:0] ramp_d;

   // Sequencer
   sto_state_e state_q;
   sto_state_e state_d;
   logic brake_q;
   logic brake_d;
   logic engage_q;
   logic engage_d;
   logic en_q;
   logic en_d;
   logic relay_q;
   logic relay_d;

   // Pulse-loss watchdog of the driver stage
   logic [OSC_W-1:0] loss_q;
   logic [OSC_W-1:0] loss_d;
   logic pulse_prev_q;
   logic alive_q;
   logic alive_d;

   // Decoded conditions
   logic inputs_ready;
   logic holdup_running;
   logic osc_powered;
   logic slow;
   logic [MS_W-1:0] ramp_limit;
   logic [MS_W-1:0] engage_at;
   logic ramp_done;
   logic engage_due;
   logic stopping;
   logic pulse_edge;
   logic go_ready;
   logic rearm_ready;
   logic run_permit;

   // Pins come from outside the clock domain
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         low_s1_q <= 1'b0;
         low_s2_q <= 1'b0;
         high_s1_q <= 1'b0;
         high_s2_q <= 1'b0;
         aux_s1_q <= 1'b0;
         aux_s2_q <= 1'b0;
      end else begin
         low_s1_q <= safe_in_low;
         low_s2_q <= low_s1_q;
         high_s1_q <= safe_in_high;
         high_s2_q <= high_s1_q;
         aux_s1_q <= aux_supply_ok;
         aux_s2_q <= aux_s1_q;
      end
   end

   // Only one pattern of the pair permits running; open inputs read low
   assign inputs_ready = !low_s2_q && high_s2_q;

   // Ready pair with and without software enable; the second re-arms after a safe stop
   assign go_ready = inputs_ready && sw_enable;
   assign rearm_ready = inputs_ready && !sw_enable;

   // Free-running millisecond prescaler
   assign ms_tick = (tick_q == TICK_W'(MS_TICK_CYC - 1));
   assign tick_d = ms_tick ? '0 : tick_q + TICK_W'(1);

   // Prescaler register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tick_q <= '0;
      end else begin
         tick_q <= tick_d;
      end
   end

   // Hold-up: reloads while ready, runs down once the inputs drop
   assign holdup_running = (holdup_q != '0);
   assign holdup_d = inputs_ready ? MS_W'(HOLDUP_MS) :
                     (holdup_running && ms_tick) ? holdup_q - MS_W'(1) : holdup_q;
   assign osc_powered = inputs_ready || holdup_running;

   // Reset starts in the expired state so power-up is safe
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         holdup_q <= '0;
      end else begin
         holdup_q <= holdup_d;
      end
   end

   // Oscillator lives only on the hold-up supply
   sto_pulse_osc u_osc (
      .clk_sys(clk_sys),
      .rst(rst),
      .powered(osc_powered),
      .isolator_one(isolator_one),
      .isolator_two(isolator_two)
   );

   // Driver stage: each edge of channel one that matches channel two restarts a quiet count; a quiet window kills the supply
   assign pulse_edge = (isolator_one != pulse_prev_q) && (isolator_one == isolator_two);
   assign loss_d = pulse_edge ? '0 : ((loss_q == OSC_W'(OSC_LOSS_CYC)) ? loss_q : loss_q + OSC_W'(1));
   assign alive_d = pulse_edge || (alive_q && (loss_q != OSC_W'(OSC_LOSS_CYC)));

   // Watchdog registers; reset reads as pulses already lost
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         loss_q <= OSC_W'(OSC_LOSS_CYC);
         pulse_prev_q <= 1'b0;
         alive_q <= 1'b0;
      end else begin
         loss_q <= loss_d;
         pulse_prev_q <= isolator_one;
         alive_q <= alive_d;
      end
   end

   // Driver supply follows the watchdog flop
   assign driver_supply_on = alive_q;

   // Stop thresholds depend on which shutdown is running
   assign slow = below_pct(speed_actual, speed_limit_a, speed_limit_b);
   assign ramp_limit = (state_q == ST_SC_STOP) ? MS_W'(SC_RAMP_MS) : MS_W'(SW_RAMP_MS);
   assign engage_at = ramp_limit + MS_W'(brake_delay_time);
   assign ramp_done = (ramp_q >= ramp_limit);
   assign engage_due = (ramp_q >= engage_at);
   assign stopping = (state_q == ST_SW_STOP) || (state_q == ST_SC_STOP);

   // Ramp timer runs only inside a stop; cleared on entry
   assign ramp_d = !stopping ? '0 :
                   (state_d != state_q) ? '0 :
                   (ms_tick && !engage_due) ? ramp_q + MS_W'(1) : ramp_q;

   // Next-state logic
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_OFF: begin
            if (go_ready) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!inputs_ready) begin
               state_d = ST_SC_STOP;
            end else if (!sw_enable) begin
               state_d = ST_SW_STOP;
            end
         end
         ST_SW_STOP: begin
            if (!inputs_ready) begin
               state_d = ST_SC_STOP;
            end else if (engage_due) begin
               state_d = ST_OFF;
            end
         end
         ST_SC_STOP: begin
            if (engage_due) begin
               state_d = ST_SAFE;
            end
         end
         ST_SAFE: begin
            // Leaving needs a fresh ready pattern with software enable dropped
            if (rearm_ready) begin
               state_d = ST_OFF;
            end
         end
         default: begin
            state_d = ST_SAFE;
         end
      endcase
   end

   // Brake command with setpoint forced to zero, latched for the stop
   assign brake_d = stopping && (state_d == state_q) ?
                    (brake_q || slow || ramp_done) : 1'b0;

   // Holding brake engages as a stop hands over to off or safe, and stays there;
   // a software stop that turns into a circuit stop restarts its ramp without engaging
   assign engage_d = (state_d == ST_OFF) || (state_d == ST_SAFE);

   // Hardware permit and software enable together; either loss starts a timed stop that holds the stage enable on
   assign run_permit = osc_powered && sw_enable;

   // Stage enable: permit in run, held through a timed stop
   assign en_d = ((state_d == ST_RUN) && run_permit) ||
                 (state_d == ST_SW_STOP) || (state_d == ST_SC_STOP);

   // Relay: function active once hold-up has expired with inputs not ready
   assign relay_d = aux_s2_q && !inputs_ready && !holdup_running;

   // State and ramp timer registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= RST_STATE;
         ramp_q <= '0;
      end else begin
         state_q <= state_d;
         ramp_q <= ramp_d;
      end
   end

   // Brake flops; reset comes up with the holding brake engaged
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         brake_q <= RST_BRAKE;
         engage_q <= RST_ENGAGE;
      end else begin
         brake_q <= brake_d;
         engage_q <= engage_d;
      end
   end

   // Enable and relay flops; the relay is status only and carries no safety role
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         en_q <= RST_EN;
         relay_q <= RST_RELAY;
      end else begin
         en_q <= en_d;
         relay_q <= relay_d;
      end
   end

   // A dead driver supply overrides the stage enable; controller_en follows en_q alone
   assign power_stage_en = en_q && driver_supply_on;
   assign controller_en = en_q;
   assign brake_cmd = brake_q || engage_q;
   assign brake_engage = engage_q;
   assign speed_setpoint_zero = brake_q || !en_q;
   assign safe_state_relay = relay_q;
   assign seq_state = state_q;

endmodule : sto_sequencer

//--- pkg/sto_pkg.sv
package sto_pkg;

   // Control clock
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned MS_PER_S = 1000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;

   // Timing figures in milliseconds
   localparam int unsigned HOLDUP_MS = 400;
   localparam int unsigned RELAY_MIN_MS = 400;
   localparam int unsigned RELAY_MAX_MS = 1000;
   localparam int unsigned SW_RAMP_MS = 1000;
   localparam int unsigned SC_RAMP_MS = 500;

   // Widths
   localparam int unsigned SPD_W = 16;
   localparam int unsigned MS_W = 18;
   localparam int unsigned TICK_W = 24;

   // Speed threshold: below one percent of the smaller limit
   localparam int unsigned PCT_SCALE = 100;

   // Pulse oscillator: half period in cycles, and loss window for the driver stage
   localparam int unsigned OSC_HALF_CYC = 25;
   localparam int unsigned OSC_LOSS_CYC = 4 * OSC_HALF_CYC;
   localparam int unsigned OSC_W = 8;

   // Reset values
   localparam logic RST_RELAY = 1'b0;
   localparam logic RST_EN = 1'b0;
   localparam logic RST_BRAKE = 1'b0;
   localparam logic RST_ENGAGE = 1'b1;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_RUN = 3'b001,
      ST_SW_STOP = 3'b010,
      ST_SC_STOP = 3'b011,
      ST_SAFE = 3'b100
   } sto_state_e;

   // Power-up state: safe, so a restart needs a fresh ready pair
   localparam sto_state_e RST_STATE = ST_SAFE;

endpackage : sto_pkg

//--- logic/sto_pulse_osc.sv
`timescale 1ns/1ps

// Fixed-frequency pulse source feeding both isolators
module sto_pulse_osc (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic powered,
   output logic isolator_one,
   output logic isolator_two
);
   import sto_pkg::*;

   logic [OSC_W-1:0] div_q;
   logic [OSC_W-1:0] div_d;
   logic phase_q;
   logic phase_d;
   logic wrap;

   // Half-period divider; stops dead when unpowered
   assign wrap = (div_q == OSC_W'(OSC_HALF_CYC - 1));
   assign div_d = (!powered || wrap) ? '0 : div_q + OSC_W'(1);
   assign phase_d = !powered ? 1'b0 : (wrap ? ~phase_q : phase_q);

   // Divider and phase registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         div_q <= '0;
         phase_q <= 1'b0;
      end else begin
         div_q <= div_d;
         phase_q <= phase_d;
      end
   end

   // Both channels carry the same train, so one stuck channel is visible downstream
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         isolator_one <= 1'b0;
         isolator_two <= 1'b0;
      end else begin
         isolator_one <= phase_q;
         isolator_two <= phase_q;
      end
   end

endmodule : sto_pulse_osc

//--- tb/sto_checker.sv
`timescale 1ns/1ps

// Pin-level watch on the sequencer
module sto_checker #(
   parameter int unsigned MS_TICK_CYC = 10
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic aux_supply_ok,
   input wire logic sw_enable,
   input wire logic [sto_pkg::SPD_W-1:0] brake_delay_time,
   input wire logic isolator_one,
   input wire logic isolator_two,
   input wire logic driver_supply_on,
   input wire logic power_stage_en,
   input wire logic controller_en,
   input wire logic brake_engage,
   input wire logic safe_state_relay,
   input wire logic [2:0] seq_state
);
   import sto_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic [7:0] quiet_q;
   logic [19:0] stop_q;
   logic [2:0] prev_q;
   wire in_stop = (seq_state == ST_SW_STOP) || (seq_state == ST_SC_STOP);
   wire [31:0] ramp_ms = (seq_state == ST_SW_STOP) ? SW_RAMP_MS : SC_RAMP_MS;
   wire [31:0] stop_lim = (ramp_ms + brake_delay_time) * MS_TICK_CYC + 8;
   // Quiet span saturates so it never wraps back into range
   always_ff @(posedge clk_sys) begin
      prev_q <= seq_state;
      if (rst || isolator_one) quiet_q <= '0;
      else if (quiet_q != 8'hFF) quiet_q <= quiet_q + 8'h01;
      if (rst || !in_stop || seq_state != prev_q) stop_q <= '0;
      else stop_q <= stop_q + 20'h00001;
   end
   sequence s_go;
      $rose(seq_state == ST_RUN);
   endsequence
   a_iso_agree: assert property (isolator_one == isolator_two) else $error("isolators differ");
   a_osc_half: assert property ($rose(isolator_one) |-> ##25 !isolator_one)
      else $error("pulse high half wrong");
   a_quiet_off: assert property (quiet_q > 8'd110 |-> !driver_supply_on)
      else $error("driver supply without pulses");
   a_idle_no_stage: assert property ((seq_state == ST_OFF || seq_state == ST_SAFE)[*2] |-> !power_stage_en)
      else $error("stage on while idle");
   a_run_needs_sw: assert property (s_go |-> $past(sw_enable)) else $error("run without software enable");
   a_ctrl_after_run: assert property (s_go |=> controller_en) else $error("controller not enabled");
   a_relay_aux: assert property (!aux_supply_ok [*4] |-> !safe_state_relay)
      else $error("relay closed without aux");
   a_relay_not_run: assert property (safe_state_relay |-> seq_state != ST_RUN)
      else $error("relay closed while running");
   a_engage_off: assert property (brake_engage |-> !controller_en)
      else $error("controller on with brake engaged");
   a_stop_bound: assert property (in_stop |-> stop_q <= stop_lim)
      else $error("stop sequence overran");
endmodule : sto_checker

bind sto_sequencer sto_checker #(.MS_TICK_CYC(MS_TICK_CYC)) u_chk (.clk_sys(clk_sys), .rst(rst),
   .aux_supply_ok(aux_supply_ok), .sw_enable(sw_enable), .brake_delay_time(brake_delay_time),
   .isolator_one(isolator_one), .isolator_two(isolator_two), .driver_supply_on(driver_supply_on),
   .power_stage_en(power_stage_en), .controller_en(controller_en), .brake_engage(brake_engage),
   .safe_state_relay(safe_state_relay), .seq_state(seq_state));

//--- tb/sto_contacts.sv
`timescale 1ns/1ps

// Safety switch contacts: 0 ready, 1 open, 2 both high, 3 both low
module sto_contacts (
   input wire logic clk_sys,
   input wire logic [1:0] mode,
   output logic safe_in_low,
   output logic safe_in_high
);
   // Open contacts read as the pull-down level
   always_ff @(posedge clk_sys) begin
      safe_in_low <= (mode == 2'd2);
      safe_in_high <= (mode == 2'd0) || (mode == 2'd2);
   end
   // Brake supply is not modelled; the outside party cuts it itself
endmodule : sto_contacts

//--- tb/tb_top.sv
`timescale 1ns/1ps

module tb_top;
   import sto_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [1:0] mode = 2'd1;
   logic sw_enable = 1'b0;
   logic aux_supply_ok = 1'b1;
   logic [15:0] speed_actual = 16'h0100;
   logic [15:0] speed_limit_a = 16'h0FA0;
   logic [15:0] speed_limit_b = 16'h1388;
   logic [15:0] brake_delay_time = 16'h0014;
   logic safe_in_low, safe_in_high, iso1, iso2, dso, pse, cen, bcmd, beng, szero, relay;
   logic [2:0] seq_state;
   int failures = 0;
   int comparisons = 0;
   always #20 clk_sys = ~clk_sys;
   sto_contacts u_sw (.clk_sys(clk_sys), .mode(mode), .safe_in_low(safe_in_low), .safe_in_high(safe_in_high));
   // Short ms tick keeps the run brief; 1 ms is 10 cycles
   sto_sequencer #(.MS_TICK_CYC(10)) uut (.clk_sys(clk_sys), .rst(rst), .safe_in_low(safe_in_low),
      .safe_in_high(safe_in_high), .aux_supply_ok(aux_supply_ok), .sw_enable(sw_enable),
      .speed_actual(speed_actual), .speed_limit_a(speed_limit_a), .speed_limit_b(speed_limit_b),
      .brake_delay_time(brake_delay_time), .isolator_one(iso1), .isolator_two(iso2), .driver_supply_on(dso),
      .power_stage_en(pse), .controller_en(cen), .brake_cmd(bcmd), .brake_engage(beng),
      .speed_setpoint_zero(szero), .safe_state_relay(relay), .seq_state(seq_state));
   task tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick
   task chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Bounded wait for a sequencer state
   task wait_st(input logic [2:0] st);
      int i;
      for (i = 0; i < 50 && seq_state !== st; i++) tick(1);
      chk(seq_state, st);
   endtask : wait_st
   task summarize;
      if (failures == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   // Watchdog: the tests need about 33000 cycles
   initial begin
      repeat (50000) @(posedge clk_sys);
      failures++;
      summarize();
   end
   initial begin
      tick(3);
      rst = 1'b0;
      chk({seq_state, beng, relay, pse}, {ST_SAFE, 3'b100});
      sw_enable = 1'b1;
      for (int m = 1; m < 4; m++) begin
         mode = m[1:0];
         tick(20);
         chk(seq_state, ST_SAFE);
      end
      mode = 2'd0;
      tick(20);
      chk(seq_state, ST_SAFE);
      sw_enable = 1'b0;
      wait_st(ST_OFF);
      tick(150);
      chk(pse, 1'b0);
      sw_enable = 1'b1;
      wait_st(ST_RUN);
      tick(150);
      chk({cen, dso, pse, szero}, 4'b1110);
      // Inputs driven both high with the motor still fast
      mode = 2'd2;
      wait_st(ST_SC_STOP);
      tick(3900);
      chk({relay, dso, bcmd}, 3'b010);
      tick(1000);
      chk({relay, pse, bcmd, beng}, 4'b1000);
      aux_supply_ok = 1'b0;
      tick(6);
      chk(relay, 1'b0);
      aux_supply_ok = 1'b1;
      tick(200);
      chk({bcmd, szero, beng}, 3'b110);
      tick(200);
      chk({seq_state, beng, cen}, {ST_SAFE, 2'b10});
      // Software stop at the speed threshold, then just below it
      mode = 2'd0;
      sw_enable = 1'b0;
      wait_st(ST_OFF);
      sw_enable = 1'b1;
      wait_st(ST_RUN);
      speed_actual = 16'h0028;
      sw_enable = 1'b0;
      wait_st(ST_SW_STOP);
      tick(5000);
      chk(bcmd, 1'b0);
      speed_actual = 16'h0027;
      tick(4);
      chk({bcmd, szero, beng}, 3'b110);
      tick(5100);
      chk({beng, cen}, 2'b01);
      tick(200);
      chk({seq_state, beng, cen}, {ST_OFF, 2'b10});
      // Limits swapped, longer brake delay: the smaller limit sets the threshold, ramp times out
      speed_limit_a = 16'h1388;
      speed_limit_b = 16'h0FA0;
      brake_delay_time = 16'h0032;
      speed_actual = 16'h0028;
      sw_enable = 1'b1;
      wait_st(ST_RUN);
      sw_enable = 1'b0;
      wait_st(ST_SW_STOP);
      tick(9900);
      chk(bcmd, 1'b0);
      tick(200);
      chk({bcmd, szero, beng, cen}, 4'b1101);
      tick(300);
      chk({seq_state, beng}, {ST_SW_STOP, 1'b0});
      tick(200);
      chk({seq_state, beng, cen}, {ST_OFF, 2'b10});
      // Both-high inputs during a software stop take over with the circuit stop's own shorter ramp
      sw_enable = 1'b1;
      wait_st(ST_RUN);
      sw_enable = 1'b0;
      wait_st(ST_SW_STOP);
      tick(100);
      mode = 2'd2;
      wait_st(ST_SC_STOP);
      speed_actual = 16'h0027;
      tick(4);
      chk({bcmd, szero, beng}, 3'b110);
      tick(5400);
      chk({seq_state, relay, beng}, {ST_SC_STOP, 2'b10});
      tick(200);
      chk({seq_state, beng, cen}, {ST_SAFE, 2'b10});
      summarize();
   end
endmodule : tb_top
